/* File: verilog/sclk_regs.svh */
// Constants for the system clock and reset pin block.
// Assumes inclusion by bare name from verilog/ sources.
`ifndef SCLK_REGS_SVH
`define SCLK_REGS_SVH
// Divide select reset value: divided setting
`define SCLK_DIV_SEL_RST   1'b1
// Oscillator prescale when divided
`define SCLK_PRE_DIV       4
// System clock to instruction clock ratio
`define SCLK_INSTR_DIV     3
// Cycles the reset pin is held low after a reset cause
`define SCLK_RST_HOLD      8
`endif

/* File: verilog/sclk_pkg.sv */
// Types shared by the clock and reset pin block.
// Assumes nothing beyond a SystemVerilog compiler.
package sclk_pkg;
    typedef enum logic [1:0] {
        SCLK_RUN,
        SCLK_HOLD
    } sclk_rst_state_t;
endpackage

/* File: verilog/sclk_if.sv */
// Carrier between the top and the instruction divider.
// Assumes both ends share sys_clk_i.
`timescale 1ns/1ps
interface sclk_if;
    logic sys_tick;     // One selected system clock edge
    logic instr_tick;   // One machine cycle boundary
    modport src (output sys_tick, input instr_tick);
    modport div (input sys_tick, output instr_tick);
endinterface // sclk_if

/* File: verilog/sclk_instr_div.sv */
// Divides system clock ticks by three into machine cycles.
// Assumes one-cycle sys_tick pulses from the selector.
`timescale 1ns/1ps
`include "sclk_regs.svh"
module sclk_instr_div (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,
    // Ticks
    sclk_if.div       bus
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       tick;
    } sclk_div_st_t;
    sclk_div_st_t st, next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (bus.sys_tick) begin
            if (st.cnt == 2'(`SCLK_INSTR_DIV - 1)) begin
                next_st.cnt  = 2'h0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 2'h1;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bus.instr_tick = st.tick;
endmodule // sclk_instr_div

/* File: verilog/sclk_top.sv */
// System clock selection, instruction clock and reset pin drive.
// Holds the oscillator prescaler, the select switch-over and the
// open-drain reset pin sequencer; the divide by three sits below.
// Assumes oscillator_input_i is a synchronous level on sys_clk_i,
// low for at least one cycle between two rises.
// Assumes the select register sits outside and writes via a strobe.
// Assumes a pull-up on the reset pin, so a released pin reads high.
// Limitation: a select write seen during a reset hold is lost.
// Trade-off: the pin sequencer counts system cycles, not oscillator ones.
// Overview of operation
// - System clock is oscillator undivided when select is 0, /4 when 1.
// - After reset the divide-by-four source is selected.
// - Instruction clock is the selected system clock divided by three.
// - One instruction clock period is one machine cycle.
// - Watchdog or low-supply reset pulls the open-drain reset pin low.
// - Voltage detector runs only while its enable pin is high.
`timescale 1ns/1ps
`include "sclk_regs.svh"

module sclk_top #(
    // Oscillator rises per system clock tick when divided
    parameter int PRE_DIV     = `SCLK_PRE_DIV,
    // Cycles the reset pin stays low after the last cause
    parameter int HOLD_CYCLES = `SCLK_RST_HOLD
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_b_i,

    // Oscillator and software control
    input  wire logic oscillator_input_i,
    input  wire logic clock_divide_select_i,
    input  wire logic select_write_i,

    // Reset causes and detector
    input  wire logic watchdog_expired_i,
    input  wire logic low_supply_i,
    input  wire logic detector_enable_pin_i,

    // Reset pin, open drain
    input  wire logic reset_pin_i,
    output logic      reset_pin_o,
    output logic      reset_pin_oe_b_o,

    // Clock outputs
    output logic      sys_tick_o,
    output logic      instr_tick_o,

    // Status outputs
    output logic      clock_divide_select_o,
    output logic      detector_running_o,
    output logic      system_reset_o
);

    // Counter widths; one bit at least for tiny settings
    localparam int PRE_W  = (PRE_DIV > 2) ? $clog2(PRE_DIV) : 1;
    localparam int HOLD_W = (HOLD_CYCLES > 2) ? $clog2(HOLD_CYCLES) : 1;

    // All state outside the divider in one word
    typedef struct packed {
        logic                      osc_q;     // Last oscillator sample
        logic [PRE_W-1:0]          pre;       // Prescale count, divided
        logic                      sel;       // Applied divide select
        logic                      sel_pend;  // Write awaiting boundary
        logic                      sel_req;   // Value of that write
        logic                      tick;      // System clock tick
        sclk_pkg::sclk_rst_state_t rst_st;    // Reset pin state
        logic [HOLD_W-1:0]         hold;      // Hold cycles left
        logic                      run;       // Detector running
    } sclk_st_t;

    // State and its next value
    sclk_st_t st;
    sclk_st_t next_st;

    // Carrier to the instruction divider
    sclk_if   link ();

    // Decoded conditions of the current cycle
    logic     osc_rise;   // Oscillator rising edge
    logic     cause;      // Reset cause accepted
    logic     in_hold;    // Reset pin held low
    logic     boundary;   // Machine cycle boundary
    logic     pre_wrap;   // Prescaler at its last count
    logic     div_rst_b;  // Divider reset, also during hold

    // Edge of the sampled oscillator level
    assign osc_rise = oscillator_input_i & ~st.osc_q;

    // detector gated by pin
    // Low supply counts only once the enable has been registered
    assign cause = watchdog_expired_i | (low_supply_i & st.run);

    // Reset pin state decode
    assign in_hold = (st.rst_st == sclk_pkg::SCLK_HOLD);

    // machine cycle boundary from the divider
    assign boundary = link.instr_tick;

    // Last prescaler count before a divided tick
    assign pre_wrap = (st.pre == PRE_W'(PRE_DIV - 1));

    // divider restarts with rst_b_i and every reset hold, not on an external pin low
    // A machine cycle cut by a reset would otherwise come out short
    assign div_rst_b = rst_b_i & ~in_hold;

    // Next state of the whole block
    always_comb begin
        // Defaults: hold state, drop the one-cycle tick
        next_st       = st;
        next_st.osc_q = oscillator_input_i;
        next_st.tick  = 1'b0;
        next_st.run   = detector_enable_pin_i;

        // Software write waits for the next boundary
        if (select_write_i) begin
            next_st.sel_pend = 1'b1;
            next_st.sel_req  = clock_divide_select_i;
        end

        if (osc_rise) begin
            if (st.sel) begin
                if (pre_wrap) begin
                    next_st.pre  = '0;
                    next_st.tick = 1'b1;
                end else begin
                    next_st.pre = st.pre + PRE_W'(1);
                end
            end else begin
                // Undivided: every rise is a tick
                next_st.tick = 1'b1;
            end
        end

        // switch at cycle boundary
        // Prescaler restarts so the first divided tick is whole
        if (st.sel_pend && boundary) begin
            next_st.sel      = select_write_i ? clock_divide_select_i
                                              : st.sel_req;
            next_st.sel_pend = select_write_i;
            next_st.pre      = '0;
        end

        case (st.rst_st)
            sclk_pkg::SCLK_RUN: begin
                // Any accepted cause starts a hold
                if (cause) begin
                    next_st.rst_st = sclk_pkg::SCLK_HOLD;
                    next_st.hold   = HOLD_W'(HOLD_CYCLES - 1);
                end
            end
            sclk_pkg::SCLK_HOLD: begin
                if (cause) begin
                    // A new cause restarts the full hold
                    next_st.hold = HOLD_W'(HOLD_CYCLES - 1);
                end else if (st.hold == '0) begin
                    // Hold count ran out: release the pin
                    next_st.rst_st = sclk_pkg::SCLK_RUN;
                end else begin
                    next_st.hold = st.hold - HOLD_W'(1);
                end
            end
            default: begin
                // Unused encoding falls back to run
                next_st.rst_st = sclk_pkg::SCLK_RUN;
            end
        endcase

        // internal reset returns select to divided
        // A write seen during the hold is dropped, not deferred
        if (in_hold) begin
            next_st.sel      = `SCLK_DIV_SEL_RST;
            next_st.sel_pend = 1'b0;
            next_st.pre      = '0;
        end
    end

    // State register; divided after reset
    // Only select and its request start divided; all else is zero
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            st         <= '0;
            st.sel     <= `SCLK_DIV_SEL_RST;
            st.sel_req <= `SCLK_DIV_SEL_RST;
            st.rst_st  <= sclk_pkg::SCLK_RUN;
        end else begin
            st <= next_st;
        end
    end

    // Selected system clock tick to the divider
    assign link.sys_tick = st.tick;

    // divide by three into machine cycles
    sclk_instr_div u_div (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (div_rst_b),
        .bus       (link)
    );

    // pin drives low only; enable active low
    assign reset_pin_o      = 1'b0;
    assign reset_pin_oe_b_o = ~in_hold;

    // Clock outputs
    assign sys_tick_o   = st.tick;
    assign instr_tick_o = link.instr_tick;

    // Status outputs
    assign clock_divide_select_o = st.sel;
    assign detector_running_o    = st.run;

    // External pin low also resets the system
    // Combinational, so a pin pulled low elsewhere acts at once
    assign system_reset_o = in_hold | ~reset_pin_i;

endmodule // sclk_top

/* File: dv/sclk_chk.sv */
// Checker for the clock and reset pin block, top ports only.
// Assumes oscillator rises at least two cycles apart.
`timescale 1ns/1ps
module sclk_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Inputs watched
    input wire logic oscillator_input_i,
    input wire logic watchdog_expired_i,
    input wire logic low_supply_i,
    // Outputs watched
    input wire logic reset_pin_oe_b_o,
    input wire logic detector_running_o,
    input wire logic sys_tick_o,
    input wire logic instr_tick_o,
    input wire logic clock_divide_select_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic [1:0] sys_cnt;  // System ticks in this machine cycle
    logic       cause;
    assign cause = watchdog_expired_i | (low_supply_i & detector_running_o);
    // Cleared in hold, as the divider is held in reset there
    always_ff @(posedge sys_clk_i)
        if (!rst_b_i || !reset_pin_oe_b_o) sys_cnt <= 2'h0;
        else if (instr_tick_o) sys_cnt <= {1'b0, sys_tick_o};
        else sys_cnt <= sys_cnt + {1'b0, sys_tick_o};
    sequence s_lone_cause;
        cause ##1 !cause [*8];
    endsequence
    a_fast_tick: assert property (
        $rose(oscillator_input_i) && !clock_divide_select_o |=> sys_tick_o)
        else $error("undivided tick missing");
    a_slow_gap: assert property (
        sys_tick_o && clock_divide_select_o |=> !sys_tick_o [*2])
        else $error("divided ticks too close");
    a_reset_div: assert property (
        $rose(rst_b_i) |-> clock_divide_select_o)
        else $error("divided source not selected");
    a_instr_three: assert property (
        instr_tick_o |-> sys_cnt == 2'h3) else $error("machine cycle length");
    a_sel_edge: assert property (
        $changed(clock_divide_select_o) && reset_pin_oe_b_o
        |-> $past(instr_tick_o)) else $error("select switched mid cycle");
    a_hold_low: assert property (
        cause |=> !reset_pin_oe_b_o [*8]) else $error("pin not held low");
    a_hold_end: assert property (
        s_lone_cause |=> reset_pin_oe_b_o) else $error("pin held too long");
endmodule // sclk_chk

/* File: dv/sclk_top_test.sv */
// Self-checking bench for the clock and reset pin block.
// Assumes the reset pin has a pull-up and the checker is bound below.
`timescale 1ns/1ps
module sclk_top_test;
    logic sys_clk_i = 1'b0, rst_b_i = 1'b0, oscillator_input_i = 1'b0;
    logic clock_divide_select_i = 1'b0, select_write_i = 1'b0;
    logic watchdog_expired_i = 1'b0, low_supply_i = 1'b0;
    logic detector_enable_pin_i = 1'b0, reset_pin_i, reset_pin_o;
    logic reset_pin_oe_b_o, sys_tick_o, instr_tick_o, system_reset_o;
    logic clock_divide_select_o, detector_running_o;
    int   err_total = 0, checked = 0, cyc = 0, nsys, ninst, nlow;
    // Open-drain pin seen through its pull-up
    assign reset_pin_i = reset_pin_oe_b_o;
    sclk_top uut (.*);
    always #25 sys_clk_i = ~sys_clk_i;
    // Tick counts and run ceiling
    always @(posedge sys_clk_i) begin
        nsys += sys_tick_o;
        ninst += instr_tick_o;
        if (++cyc == 3000) begin
            err_total++;
            final_report;
        end
    end
    task chk(string n, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %0h seen %0h", n, exp, seen);
        end
    endtask
    // Oscillator pulses two cycles apart, then let ticks settle
    task rises(int n);
        nsys = 0;
        ninst = 0;
        repeat (n) begin
            @(negedge sys_clk_i) oscillator_input_i = 1'b1;
            @(negedge sys_clk_i) oscillator_input_i = 1'b0;
        end
        repeat (3) @(negedge sys_clk_i);
    endtask
    // One-cycle reset cause; counts cycles the pin is driven low
    task hold(bit wd);
        nlow = 0;
        @(negedge sys_clk_i);
        watchdog_expired_i = wd;
        low_supply_i = !wd;
        @(negedge sys_clk_i);
        watchdog_expired_i = 1'b0;
        low_supply_i = 1'b0;
        repeat (12) begin
            if (!reset_pin_oe_b_o && !reset_pin_o && system_reset_o) nlow++;
            @(negedge sys_clk_i);
        end
    endtask
    task t_divided;
        chk("select", clock_divide_select_o, 8'h1);
        rises(24);
        chk("sys ticks", 8'(nsys), 8'h06);
        chk("instr ticks", 8'(ninst), 8'h02);
        $display("test divided done");
    endtask
    task t_switch;
        clock_divide_select_i = 1'b0;
        select_write_i = 1'b1;
        @(negedge sys_clk_i) select_write_i = 1'b0;
        rises(6);
        chk("select held", clock_divide_select_o, 8'h1);
        rises(6);
        chk("select applied", clock_divide_select_o, 8'h0);
        rises(9);
        chk("sys ticks", 8'(nsys), 8'h09);
        chk("instr ticks", 8'(ninst), 8'h03);
        $display("test switch done");
    endtask
    task t_reset;
        hold(1'b0);
        chk("detector off", 8'(nlow), 8'h00);
        detector_enable_pin_i = 1'b1;
        rises(1);
        hold(1'b0);
        chk("low supply", 8'(nlow), 8'h08);
        hold(1'b1);
        chk("watchdog", 8'(nlow), 8'h08);
        chk("select forced", clock_divide_select_o, 8'h1);
        rises(8);
        chk("restart sys ticks", 8'(nsys), 8'h02);
        chk("restart instr ticks", 8'(ninst), 8'h00);
        $display("test reset done");
    endtask
    // Undivided select applied, then a mid-run reset
    task t_restart;
        select_write_i = 1'b1;
        @(negedge sys_clk_i) select_write_i = 1'b0;
        rises(4);
        chk("select undivided", clock_divide_select_o, 8'h0);
        chk("boundary tick", 8'(ninst), 8'h01);
        rst_b_i = 1'b0;
        repeat (5) @(posedge sys_clk_i);
        @(negedge sys_clk_i) rst_b_i = 1'b1;
        @(negedge sys_clk_i);
        chk("select after reset", clock_divide_select_o, 8'h1);
        $display("test restart done");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk_i);
        @(negedge sys_clk_i) rst_b_i = 1'b1;
        @(negedge sys_clk_i);
        t_divided;
        t_switch;
        t_reset;
        t_restart;
        final_report;
    end
endmodule // sclk_top_test
bind sclk_top sclk_chk chk_i (.*);
